// ==== logic/chirp_pkg.sv ====
// Purpose: constants for the chirp and phase-keying update control block
// Assumes: registers reached by a simple write/read port at printed offsets
// Notes on behaviour
// - Delta step word is two's complement; MSB one sweeps down, zero sweeps up.
// - Written settings stay buffered until an update edge transfers them.
// - Chirp never returns or stops on its own; it wraps freely.
// - Setting the accumulator clear bit gives a one-cycle pulse zeroing the frequency accumulator.
// - Held clear bit re-fires that pulse on every update edge.
// - Full clear bit holds both accumulators at zero while high.
// - Register writes are accepted while the full clear bit is high.
// - Freeze pin in chirp mode stops the dwell counter and thus the sweep.
// - After freeze, countdown finishes at old rate before a new dwell loads.
// - An all-zero delta step word holds the frequency reached.
// - In mode 100 the phase pin picks phase word one (low) or two (high).
// - Buffered registers copy to the active core only on an update rising edge.
// - External update edges are synchronised to the clock before transfer.
// - Update source bit resets to internal; zero selects external update input.
// - Internal update counter ticks at half rate; period (N+1) times two clocks.
// - In internal mode each update pulse is driven out on the update pin.
// - Each driven update pulse stays high exactly eight clocks, except one clock for the update that switches to external update.
// - With an update count below five the update pin stays high.
// - Each dwell counter pulse adds the delta step word to the frequency accumulator.
// - Dwell counter counts down N at the clock, one pulse per N+1 clocks.
package chirp_pkg;
  // Register offsets (most significant byte of each multi-byte register)
  localparam logic [7:0] OFF_PHASE_ONE = 8'h00;
  localparam logic [7:0] OFF_PHASE_TWO = 8'h02;
  localparam logic [7:0] OFF_START_TUNING = 8'h04;
  localparam logic [7:0] OFF_DELTA_STEP = 8'h10;
  localparam logic [7:0] OFF_UPDATE_PERIOD = 8'h16;
  localparam logic [7:0] OFF_STEP_DWELL = 8'h1A;
  localparam logic [7:0] OFF_CONTROL = 8'h1F;
  // Control byte field positions
  localparam int CTL_FULL_CLEAR = 7;
  localparam int CTL_ACC_CLEAR = 6;
  localparam int CTL_MODE_LSB = 1;
  localparam int CTL_INT_UPDATE = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h01;
  // Mode codes
  localparam logic [2:0] MODE_CHIRP = 3'h3;
  localparam logic [2:0] MODE_BPSK = 3'h4;
  // Update pin timing
  localparam int UPDATE_PULSE_CYCLES = 8;
  localparam logic [31:0] UPDATE_SHORT_LIMIT = 32'h0000_0005;
endpackage : chirp_pkg

// ==== logic/chirp_update_ctrl.sv ====
// Purpose: chirp sweep, phase keying and update clock control
// Assumes: byte-wide register writes at printed offsets, one 10 MHz clock
// Notes: update pin is three signals; host drives it only in external mode
module chirp_update_ctrl #(
  parameter int FREQ_W = 48,
  parameter int DWELL_W = 20,
  parameter int PHASE_W = 14
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic freezePin,
  input wire logic updateIn,
  output logic updateOut,
  output logic updateOe,
  output logic [FREQ_W-1:0] freqWord,
  output logic [FREQ_W-1:0] phaseAcc,
  output logic [PHASE_W-1:0] phaseOffset
);
  // Register map and field slices are fixed, so other widths are refused
  if (FREQ_W != 48 || DWELL_W != 20 || PHASE_W != 14) begin : g_width_check
    $error("chirp_update_ctrl: widths are fixed");
  end

  // Reset release through two flops
  logic rstMeta_q;
  logic rstN;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rstMeta_q <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN <= rstMeta_q;
    end
  end

  // Buffered registers, written by the host
  logic [47:0] bufStart_q, bufStart_d;
  logic [47:0] bufDelta_q, bufDelta_d;
  logic [31:0] bufPeriod_q, bufPeriod_d;
  logic [19:0] bufDwell_q, bufDwell_d;
  logic [13:0] bufPh1_q, bufPh1_d;
  logic [13:0] bufPh2_q, bufPh2_d;
  logic [7:0] bufCtl_q, bufCtl_d;
  // Active core copies
  logic [47:0] actStart_q, actStart_d;
  logic [47:0] actDelta_q, actDelta_d;
  logic [31:0] actPeriod_q, actPeriod_d;
  logic [19:0] actDwell_q, actDwell_d;
  logic [13:0] actPh1_q, actPh1_d;
  logic [13:0] actPh2_q, actPh2_d;
  logic [7:0] actCtl_q, actCtl_d;
  logic updateEdge;
  logic [7:0] rd_d;

  // Byte writes into buffers, accepted in every state
  always_comb begin
    logic [7:0] idx;
    idx = 8'h00;
    bufStart_d = bufStart_q;
    bufDelta_d = bufDelta_q;
    bufPeriod_d = bufPeriod_q;
    bufDwell_d = bufDwell_q;
    bufPh1_d = bufPh1_q;
    bufPh2_d = bufPh2_q;
    bufCtl_d = bufCtl_q;
    if (regWrite) begin
      if (regAddr >= chirp_pkg::OFF_START_TUNING && regAddr < chirp_pkg::OFF_START_TUNING + 8'h06) begin
        idx = regAddr - chirp_pkg::OFF_START_TUNING;
        bufStart_d[8*(5-idx[2:0]) +: 8] = regWdata;
      end else if (regAddr >= chirp_pkg::OFF_DELTA_STEP && regAddr < chirp_pkg::OFF_DELTA_STEP + 8'h06) begin
        idx = regAddr - chirp_pkg::OFF_DELTA_STEP;
        bufDelta_d[8*(5-idx[2:0]) +: 8] = regWdata;
      end else if (regAddr >= chirp_pkg::OFF_UPDATE_PERIOD && regAddr < chirp_pkg::OFF_UPDATE_PERIOD + 8'h04) begin
        idx = regAddr - chirp_pkg::OFF_UPDATE_PERIOD;
        bufPeriod_d[8*(3-idx[1:0]) +: 8] = regWdata;
      end else if (regAddr == chirp_pkg::OFF_STEP_DWELL) begin
        bufDwell_d[19:16] = regWdata[3:0];
      end else if (regAddr == chirp_pkg::OFF_STEP_DWELL + 8'h01) begin
        bufDwell_d[15:8] = regWdata;
      end else if (regAddr == chirp_pkg::OFF_STEP_DWELL + 8'h02) begin
        bufDwell_d[7:0] = regWdata;
      end else if (regAddr == chirp_pkg::OFF_PHASE_ONE) begin
        bufPh1_d[13:8] = regWdata[5:0];
      end else if (regAddr == chirp_pkg::OFF_PHASE_ONE + 8'h01) begin
        bufPh1_d[7:0] = regWdata;
      end else if (regAddr == chirp_pkg::OFF_PHASE_TWO) begin
        bufPh2_d[13:8] = regWdata[5:0];
      end else if (regAddr == chirp_pkg::OFF_PHASE_TWO + 8'h01) begin
        bufPh2_d[7:0] = regWdata;
      end else if (regAddr == chirp_pkg::OFF_CONTROL) begin
        bufCtl_d = regWdata;
      end
    end
  end

  // Transfer to core only on an update edge
  always_comb begin
    actStart_d = updateEdge ? bufStart_q : actStart_q;
    actDelta_d = updateEdge ? bufDelta_q : actDelta_q;
    actPeriod_d = updateEdge ? bufPeriod_q : actPeriod_q;
    actDwell_d = updateEdge ? bufDwell_q : actDwell_q;
    actPh1_d = updateEdge ? bufPh1_q : actPh1_q;
    actPh2_d = updateEdge ? bufPh2_q : actPh2_q;
    actCtl_d = updateEdge ? bufCtl_q : actCtl_q;
  end

  // Read back of the buffered control byte, unmapped reads zero
  always_comb begin
    rd_d = 8'h00;
    if (regAddr == chirp_pkg::OFF_CONTROL) begin
      rd_d = bufCtl_q;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      bufStart_q <= 48'h0; bufDelta_q <= 48'h0; bufPeriod_q <= 32'h0; bufDwell_q <= 20'h0;
      bufPh1_q <= 14'h0; bufPh2_q <= 14'h0; bufCtl_q <= chirp_pkg::CONTROL_RESET;
      actStart_q <= 48'h0; actDelta_q <= 48'h0; actPeriod_q <= 32'h0; actDwell_q <= 20'h0;
      actPh1_q <= 14'h0; actPh2_q <= 14'h0; actCtl_q <= chirp_pkg::CONTROL_RESET;
      regRdata <= 8'h00;
    end else begin
      bufStart_q <= bufStart_d; bufDelta_q <= bufDelta_d; bufPeriod_q <= bufPeriod_d;
      bufDwell_q <= bufDwell_d; bufPh1_q <= bufPh1_d; bufPh2_q <= bufPh2_d; bufCtl_q <= bufCtl_d;
      actStart_q <= actStart_d; actDelta_q <= actDelta_d; actPeriod_q <= actPeriod_d;
      actDwell_q <= actDwell_d; actPh1_q <= actPh1_d; actPh2_q <= actPh2_d; actCtl_q <= actCtl_d;
      regRdata <= rd_d;
    end
  end

  // Control fields of the active core
  logic intMode, accClear, fullClear;
  logic [2:0] mode;
  assign intMode = actCtl_q[chirp_pkg::CTL_INT_UPDATE];
  assign accClear = actCtl_q[chirp_pkg::CTL_ACC_CLEAR];
  assign fullClear = actCtl_q[chirp_pkg::CTL_FULL_CLEAR];
  assign mode = actCtl_q[chirp_pkg::CTL_MODE_LSB +: 3];

  // Synchronisers for pins
  logic freezeSync, extSync;
  logic extRaw;
  // Own pulse on the pin is masked, so a mode switch sees no false edge
  assign extRaw = updateIn && !updateOe;
  sync_two freezeSyncInst (.clock(clock), .rstN(rstN), .din(freezePin), .dout(freezeSync));
  sync_two extSyncInst (.clock(clock), .rstN(rstN), .din(extRaw), .dout(extSync));

  // Update generator: half-rate down-counter, external edge detect, pin pulse
  logic half_q, half_d;
  logic [31:0] updCnt_q, updCnt_d;
  logic extPrev_q, extPrev_d;
  logic [3:0] pulseCnt_q, pulseCnt_d;
  logic intTick;
  logic pinHigh;
  assign intTick = intMode && half_q && (updCnt_q == 32'h0);
  assign updateEdge = intMode ? intTick : (extSync && !extPrev_q);
  always_comb begin
    half_d = ~half_q;
    updCnt_d = updCnt_q;
    if (half_q) begin
      updCnt_d = (updCnt_q == 32'h0) ? bufPeriod_q : updCnt_q - 32'h1;
    end
    extPrev_d = extSync;
    pulseCnt_d = pulseCnt_q;
    if (intTick) begin
      pulseCnt_d = 4'(chirp_pkg::UPDATE_PULSE_CYCLES);
    end else if (pulseCnt_q != 4'h0) begin
      pulseCnt_d = pulseCnt_q - 4'h1;
    end
    pinHigh = (pulseCnt_d != 4'h0) || (actPeriod_q < chirp_pkg::UPDATE_SHORT_LIMIT);
  end
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      half_q <= 1'b0;
      updCnt_q <= 32'h0;
      extPrev_q <= 1'b0;
      pulseCnt_q <= 4'h0;
      updateOut <= 1'b0;
      updateOe <= 1'b0;
    end else begin
      half_q <= half_d;
      updCnt_q <= updCnt_d;
      extPrev_q <= extPrev_d;
      pulseCnt_q <= pulseCnt_d;
      updateOut <= intMode && pinHigh;
      updateOe <= intMode;
    end
  end

  // Accumulator clear pulse: on the bit's rise or each update while held
  logic accClrPrev_q;
  logic clrPulse;
  assign clrPulse = (accClear && !accClrPrev_q) || (accClear && updateEdge);
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      accClrPrev_q <= 1'b0;
    end else begin
      accClrPrev_q <= accClear;
    end
  end

  // Dwell counter and frequency accumulator
  logic [19:0] dwell_q, dwell_d;
  logic [47:0] freqAcc_q, freqAcc_d;
  logic [47:0] phase_d;
  logic [47:0] word_d;
  logic [13:0] offs_d;
  logic dwellPulse;
  logic frozen;
  assign frozen = freezeSync && (mode == chirp_pkg::MODE_CHIRP);
  assign dwellPulse = !frozen && (dwell_q == 20'h0);
  always_comb begin
    dwell_d = dwell_q;
    if (!frozen) begin
      // Finish current countdown before taking a new value
      dwell_d = (dwell_q == 20'h0) ? actDwell_q : dwell_q - 20'h1;
    end
    freqAcc_d = freqAcc_q;
    if (fullClear || clrPulse) begin
      freqAcc_d = 48'h0;
    end else if (dwellPulse) begin
      // Signed step, wraps freely; zero step holds
      freqAcc_d = freqAcc_q + actDelta_q;
    end
    word_d = actStart_q + freqAcc_d;
    phase_d = fullClear ? 48'h0 : phaseAcc + freqWord;
    offs_d = actPh1_q;
    if (mode == chirp_pkg::MODE_BPSK && freezeSync) begin
      offs_d = actPh2_q;
    end
  end
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      dwell_q <= 20'h0;
      freqAcc_q <= 48'h0;
      freqWord <= 48'h0;
      phaseAcc <= 48'h0;
      phaseOffset <= 14'h0;
    end else begin
      dwell_q <= dwell_d;
      freqAcc_q <= freqAcc_d;
      freqWord <= fullClear ? 48'h0 : word_d;
      phaseAcc <= phase_d;
      phaseOffset <= offs_d;
    end
  end

  // Checks
  sequence s_tick;
    intTick;
  endsequence
  a_pulse_width: assert property (@(posedge clock) disable iff (!rstN)
    s_tick ##1 (actPeriod_q >= chirp_pkg::UPDATE_SHORT_LIMIT && intMode) |-> updateOut [*8])
    else $error("update pin pulse too short");
  a_full_clear: assert property (@(posedge clock) disable iff (!rstN)
    fullClear |=> (phaseAcc == 48'h0 && freqWord == 48'h0))
    else $error("full clear did not hold zero");
  a_core_hold: assert property (@(posedge clock) disable iff (!rstN)
    !updateEdge |=> $stable(actCtl_q) && $stable(actDelta_q))
    else $error("core changed without update");
  a_freeze_hold: assert property (@(posedge clock) disable iff (!rstN)
    frozen && !fullClear && !clrPulse |=> $stable(freqAcc_q))
    else $error("sweep moved while frozen");
  a_step_add: assert property (@(posedge clock) disable iff (!rstN)
    dwellPulse && !fullClear && !clrPulse |=> freqAcc_q == $past(freqAcc_q) + $past(actDelta_q))
    else $error("accumulator step wrong");
  a_clear_pulse: assert property (@(posedge clock) disable iff (!rstN)
    $rose(accClear) |=> freqAcc_q == 48'h0)
    else $error("accumulator clear missed");
  a_oe_mode: assert property (@(posedge clock) disable iff (!rstN)
    1'b1 |=> updateOe == $past(intMode))
    else $error("update pin direction wrong");
  a_short_high: assert property (@(posedge clock) disable iff (!rstN)
    intMode && actPeriod_q < chirp_pkg::UPDATE_SHORT_LIMIT |=> updateOut)
    else $error("update pin not held high");
  a_bpsk_select: assert property (@(posedge clock) disable iff (!rstN)
    mode == chirp_pkg::MODE_BPSK && freezeSync |=> phaseOffset == $past(actPh2_q))
    else $error("phase select wrong");
endmodule : chirp_update_ctrl

// ==== logic/sync_two.sv ====
// Purpose: two-flop synchroniser for a level
// Assumes: single clock, active low async reset
// Notes: first flop is read only by the second
module sync_two (
  input wire logic clock,
  input wire logic rstN,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  logic stable_q;
  // Two stage capture
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      meta_q <= 1'b0;
      stable_q <= 1'b0;
    end else begin
      meta_q <= din;
      stable_q <= meta_q;
    end
  end
  assign dout = stable_q;
endmodule : sync_two

// ==== test/chirp_bpsk_update_control_tb.sv ====
// Purpose: self-checking bench for the chirp and update control block
// Assumes: host model drives all inputs at the falling edge
// Notes: expectations come from the step, dwell and period settings
module chirp_bpsk_update_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, resetn, regWrite, freezePin, hostUpd, updPin, updateOut, updateOe;
  logic [7:0] regAddr, regWdata, regRdata, r;
  logic [47:0] freqWord, phaseAcc, f, s, s2, d, diff;
  logic [13:0] phaseOffset, p1, p2;
  int failures, n_checks, cnt, gap;
  // Update pin level from whichever side drives it
  assign updPin = updateOe ? updateOut : hostUpd;
  chirp_update_ctrl i_dut (.clock(clock), .resetn(resetn), .regWrite(regWrite), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .freezePin(freezePin), .updateIn(updPin),
    .updateOut(updateOut), .updateOe(updateOe), .freqWord(freqWord), .phaseAcc(phaseAcc),
    .phaseOffset(phaseOffset));
  chirp_host i_host (.clock(clock), .regRdata(regRdata), .regWrite(regWrite), .regAddr(regAddr),
    .regWdata(regWdata), .freezePin(freezePin), .hostUpd(hostUpd));
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  // Bounded wait for the update pin to reach a level
  task automatic lvl(input logic v, output int n);
    n = 0;
    while (updateOut !== v && n < 300) begin
      @(negedge clock);
      n++;
    end
  endtask : lvl
  // Bounded wait for the next frequency change
  task automatic chg(output int n);
    f = freqWord;
    n = 0;
    while (freqWord === f && n < 60) begin
      @(negedge clock);
      n++;
    end
  endtask : chg
  // Times and sizes one whole dwell step
  task automatic step(input logic [47:0] e);
    chg(gap);
    diff = freqWord;
    chg(gap);
    chk("dwell", 48'd5, 48'(gap));
    chk("step", e, freqWord - diff);
  endtask : step
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Watchdog
  initial begin
    #2000000;
    failures++;
    end_of_test();
  end
  // Main sequence
  initial begin
    failures = 0;
    n_checks = 0;
    resetn = 1'b0;
    void'($urandom(32537));
    cyc(2);
    resetn = 1'b1;
    cyc(4);
    i_host.rd(8'h1F, r);
    chk("control reset", 48'h01, 48'(r));
    chk("pin drive", 48'h1, 48'(updateOe));
    // Park in external mode so the set-up lands in one transfer
    i_host.wr(8'h1F, 8'h00);
    cyc(10);
    s = 48'($urandom()) << 8;
    d = 48'($urandom_range(4095, 1));
    i_host.setup(s, d, 20'h4);
    i_host.period(32'd49);
    i_host.wr(8'h1F, 8'h07);
    i_host.hostUpd = 1'b1;
    cyc(10);
    i_host.hostUpd = 1'b0;
    cyc(300);
    lvl(1'b0, cnt);
    lvl(1'b1, cnt);
    lvl(1'b0, gap);
    lvl(1'b1, cnt);
    chk("pulse high", 48'd8, 48'(gap));
    chk("period", 48'd100, 48'(gap + cnt));
    chk("origin", 48'h0, (freqWord - s) % d);
    step(d);
    i_host.wreg(8'h10, 48'(~d + 48'h1), 6);
    cyc(250);
    step(48'(~d + 48'h1));
    i_host.freezePin = 1'b1;
    cyc(6);
    s2 = freqWord;
    cyc(40);
    chk("frozen", s2, freqWord);
    i_host.freezePin = 1'b0;
    step(48'(~d + 48'h1));
    i_host.wreg(8'h10, 48'h0, 6);
    cyc(250);
    s2 = freqWord;
    cyc(60);
    chk("zero step", s2, freqWord);
    i_host.wreg(8'h10, d, 6);
    i_host.wr(8'h1F, 8'h47);
    cyc(400);
    for (int i = 0; i < 5; i++) begin
      cyc(37);
      chk("cleared sweep", 48'h1, 48'(((freqWord - s) / d) <= 48'd22));
    end
    i_host.wr(8'h1F, 8'h87);
    cyc(250);
    chk("phase held", 48'h0, phaseAcc);
    s2 = 48'($urandom()) << 8;
    i_host.wreg(8'h04, s2, 6);
    cyc(30);
    chk("phase held", 48'h0, phaseAcc);
    i_host.wr(8'h1F, 8'h07);
    cyc(300);
    chk("new start", 48'h0, (freqWord - s2) % d);
    chk("new span", 48'h1, 48'(((freqWord - s2) / d) <= 48'd70));
    p1 = 14'($urandom());
    p2 = 14'($urandom());
    i_host.wreg(8'h00, 48'(p1), 2);
    i_host.wreg(8'h02, 48'(p2), 2);
    i_host.wr(8'h1F, 8'h09);
    cyc(250);
    cyc(5);
    chk("phase one", 48'(p1), 48'(phaseOffset));
    i_host.freezePin = 1'b1;
    cyc(6);
    chk("phase two", 48'(p2), 48'(phaseOffset));
    i_host.freezePin = 1'b0;
    i_host.period(32'd3);
    cyc(300);
    cnt = 0;
    repeat (50) begin
      @(negedge clock);
      cnt += (updateOut === 1'b1) ? 1 : 0;
    end
    chk("pin high", 48'd50, 48'(cnt));
    i_host.wreg(8'h10, 48'h0, 6);
    i_host.wr(8'h1F, 8'h06);
    cyc(100);
    chk("pin released", 48'h0, 48'(updateOe));
    f = freqWord;
    s = 48'($urandom()) << 8;
    i_host.wreg(8'h04, s, 6);
    cyc(100);
    chk("buffered", f, freqWord);
    i_host.hostUpd = 1'b1;
    cyc(10);
    i_host.hostUpd = 1'b0;
    cyc(5);
    chk("external update", s + (f - s2), freqWord);
    end_of_test();
  end
endmodule : chirp_bpsk_update_control_tb

// ==== test/chirp_host.sv ====
// Purpose: host controller model driving the register port and pins
// Assumes: inputs change at the falling clock edge only
// Notes: its update drive counts only while the device releases the pin
module chirp_host (
  input wire logic clock,
  input wire logic [7:0] regRdata,
  output logic regWrite,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  output logic freezePin,
  output logic hostUpd
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle levels from time zero
  initial begin
    regWrite = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    freezePin = 1'b0;
    hostUpd = 1'b0;
  end
  // One byte write, strobe held for one clock
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = v;
    @(negedge clock);
    regWrite = 1'b0;
  endtask : wr
  // Multi-byte register, most significant byte at the lowest address
  task automatic wreg(input logic [7:0] a, input logic [47:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      wr(a + 8'(i), v[8*(n-1-i) +: 8]);
    end
  endtask : wreg
  // Read back one byte, answer one clock after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clock);
    regAddr = a;
    @(negedge clock);
    v = regRdata;
  endtask : rd
  // Sweep set-up: start word, step and dwell all before any update
  task automatic setup(input logic [47:0] s, input logic [47:0] d, input logic [19:0] m);
    wreg(8'h04, s, 6);
    wreg(8'h10, d, 6);
    wreg(8'h1A, {28'h0, m}, 3);
  endtask : setup
  // Update period, never below one
  task automatic period(input logic [31:0] n);
    wreg(8'h16, {16'h0, (n == 32'h0) ? 32'h1 : n}, 4);
  endtask : period
endmodule : chirp_host
